// ---- hdl/acc_pkg.sv ----
// acc_pkg: constants, register map and carrier types of the converter control block
// assumes a single 20 MHz system clock and an Avalon-MM register slave
`default_nettype none
package acc_pkg;
    // register byte addresses (printed offsets are not word multiples: index * 4)
    localparam logic [7:0] IDX_CONTROL  = 8'h1f;
    localparam logic [7:0] IDX_PORTCFG  = 8'h9f;
    localparam logic [7:0] IDX_RESULT   = 8'h1e;
    localparam logic [7:0] IDX_STATUS   = 8'h20;
    localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_PORTCFG = {IDX_PORTCFG, 2'b00};
    localparam logic [9:0] ADDR_RESULT  = {IDX_RESULT, 2'b00};
    localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};
    // control field positions
    localparam int CLKSEL_HI = 7;
    localparam int CLKSEL_LO = 6;
    localparam int CHAN_HI   = 4;
    localparam int CHAN_LO   = 3;
    localparam int GO_BIT    = 2;
    localparam int EN_BIT    = 0;
    localparam int RSV_HI    = 5;
    localparam int RSV_LO    = 1;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [2:0] PORTCFG_RST = 3'h0;
    // status register bits
    localparam int ST_DONE_FLAG = 0;
    localparam int ST_PIN_FLAG  = 1;
    localparam int ST_EDGE_FLAG = 2;
    localparam int ST_BUSY      = 3;
    // conversion clock dividers (system periods per conversion period)
    localparam logic [1:0] CLK_DIV2  = 2'h0;
    localparam logic [1:0] CLK_DIV8  = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC    = 2'h3;
    localparam int DIV2_HALF  = 1;   // ticks counted on half periods
    localparam int DIV8_HALF  = 4;
    localparam int DIV32_HALF = 16;
    // conversion timing in half conversion periods
    localparam int CONV_HALVES = 19;  // 9.5 periods
    localparam int HOLD_HALVES = 4;   // 2 periods disconnected
    localparam int RC_WAIT_NS  = 400; // one instruction cycle before converting
    localparam int CLK_NS      = 50;
    localparam int RC_WAIT_CYC = (RC_WAIT_NS + CLK_NS - 1) / CLK_NS;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_CONV = 3'b010,
        ST_HOLD = 3'b011
    } acc_state_t;
    // pin decode result
    typedef struct packed {
        logic [3:0] digital;   // gp4, gp2, gp1, gp0 order 3..0
        logic       ext_ref;
    } acc_pinmap_t;
    // avalon request
    typedef struct packed {
        logic [9:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } acc_req_t;
endpackage : acc_pkg
`default_nettype wire

// ---- hdl/acc_top.sv ----
// acc_top: conversion control for a four-input 8-bit successive-approximation converter
// assumes comparator and pin levels arrive asynchronously; registers over Avalon-MM
//
// Contract
// - clock select bits 7-6: sysclk/2, /8, /32, or internal RC clock
// - channel select bits 4-3 choose analog channel 0 to 3
// - start bit begins conversion when enabled, reads one while busy
// - hardware clears start bit when conversion finishes
// - enable bit zero shuts converter off
// - port config codes map pins digital; codes 001,011,101 use external reference
// - pins configured analog read as zero
// - port config resets to 000, all analog, supply reference
// - writing port config may set pin-change and edge flags
// - completion loads result, clears start bit, sets done flag together
// - sample capacitor held disconnected two conversion periods after conversion
// - conversion takes 9.5 conversion periods from start
// - successive approximation decides one bit per conversion period
// - sample capacitor never discharged between conversions
// - clearing start aborts, keeps result, new acquisition after two periods
// - RC clock waits one instruction cycle, completes during sleep
// - sleep with non-RC clock aborts and powers off, enable kept
//
// The Avalon-MM register port was decided locally.
`default_nettype none
module acc_top
    import acc_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        RC_TICK,
    input  wire logic        SLEEP,
    input  wire logic        CMP_IN,
    input  wire logic [3:0]  PIN_IN,
    output logic      [3:0]  PIN_VALUE,
    output logic      [1:0]  SAMPLE_CHANNEL,
    output logic             SAMPLE_CONNECT,
    output logic      [7:0]  DAC_CODE,
    output logic             EXT_REF,
    output logic             ANALOG_ON,
    output logic             WAKE
);
    import acc_pkg::*;

    acc_req_t    req;
    acc_state_t  state_r;
    logic [7:0]  control_r;
    logic [2:0]  portcfg_r;
    logic [7:0]  result_r;
    logic        done_flag_r;
    logic        pin_flag_r;
    logic        edge_flag_r;
    logic        ack_r;
    logic [4:0]  div_r;
    logic [4:0]  half_r;
    logic [3:0]  wait_r;
    logic [7:0]  sar_r;
    logic [2:0]  bit_r;
    logic [1:0]  rc_sync_r;
    logic        rc_prev_r;
    logic [1:0]  cmp_sync_r;
    logic [3:0]  pin_s1_r;
    logic [3:0]  pin_s2_r;
    logic [1:0]  slp_sync_r;
    logic        tick;
    logic        wr_ctl;
    logic        wr_cfg;
    logic        go_set;
    logic        go_clr;
    logic        finish;
    logic        abort;
    logic [4:0]  div_half;
    acc_pinmap_t pmap;

    // port configuration decode into digital mask and reference choice
    function automatic acc_pinmap_t decode_cfg(input logic [2:0] cfg);
        acc_pinmap_t m;
        m.ext_ref = (cfg == 3'h1) || (cfg == 3'h3) || (cfg == 3'h5);
        case (cfg)
            3'h2, 3'h3: m.digital = 4'h8;
            3'h4, 3'h5: m.digital = 4'hc;
            3'h6:       m.digital = 4'he;
            3'h7:       m.digital = 4'hf;
            default:    m.digital = 4'h0;
        endcase
        return m;
    endfunction

    assign req  = '{AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA[7:0]};
    assign pmap = decode_cfg(portcfg_r);
    assign wr_ctl = req.write && ack_r == 1'b0 && req.address == ADDR_CONTROL;
    assign wr_cfg = req.write && ack_r == 1'b0 && req.address == ADDR_PORTCFG;
    assign go_set = wr_ctl && req.writedata[GO_BIT] && control_r[EN_BIT];
    assign go_clr = wr_ctl && !req.writedata[GO_BIT];

    // input synchronisers for pins, comparator, RC tick and sleep
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            rc_sync_r  <= 2'h0;
            rc_prev_r  <= 1'b0;
            cmp_sync_r <= 2'h0;
            pin_s1_r   <= 4'h0;
            pin_s2_r   <= 4'h0;
            slp_sync_r <= 2'h0;
        end
        else
        begin
            rc_sync_r  <= {rc_sync_r[0], RC_TICK};
            rc_prev_r  <= rc_sync_r[1];
            cmp_sync_r <= {cmp_sync_r[0], CMP_IN};
            pin_s1_r   <= PIN_IN;
            pin_s2_r   <= pin_s1_r;
            slp_sync_r <= {slp_sync_r[0], SLEEP};
        end
    end

    // half-period tick from divider or either edge of the RC clock
    always_comb
    begin
        case (control_r[CLKSEL_HI:CLKSEL_LO])
            CLK_DIV2:  div_half = 5'(DIV2_HALF);
            CLK_DIV8:  div_half = 5'(DIV8_HALF);
            CLK_DIV32: div_half = 5'(DIV32_HALF);
            default:   div_half = 5'(DIV2_HALF);
        endcase
    end
    assign tick = (control_r[CLKSEL_HI:CLKSEL_LO] == CLK_RC)
                ? (rc_sync_r[1] ^ rc_prev_r) : (div_r == div_half - 5'h1);
    // sleep stops a conversion unless the RC clock drives it
    assign abort = go_clr || !control_r[EN_BIT]
                || (slp_sync_r[1] && control_r[CLKSEL_HI:CLKSEL_LO] != CLK_RC);
    assign finish = state_r == ST_CONV && tick && half_r == 5'(CONV_HALVES - 1);

    // conversion clock divider
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            div_r <= 5'h0;
        else if (state_r == ST_IDLE || tick)
            div_r <= 5'h0;
        else
            div_r <= div_r + 5'h1;
    end

    // sequencer: wait, convert 9.5 periods, hold 2 periods
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= ST_IDLE;
            half_r  <= 5'h0;
            wait_r  <= 4'h0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (go_set)
                    begin
                        state_r <= (control_r[CLKSEL_HI:CLKSEL_LO] == CLK_RC) ? ST_WAIT : ST_CONV;
                        wait_r  <= 4'h0;
                        half_r  <= 5'h0;
                    end
                ST_WAIT:
                    if (abort)
                        state_r <= ST_IDLE;
                    else if (wait_r == 4'(RC_WAIT_CYC - 1))
                        state_r <= ST_CONV;
                    else
                        wait_r <= wait_r + 4'h1;
                ST_CONV:
                    if (abort)
                    begin
                        state_r <= ST_HOLD;
                        half_r  <= 5'h0;
                    end
                    else if (finish)
                    begin
                        state_r <= ST_HOLD;
                        half_r  <= 5'h0;
                    end
                    else if (tick)
                        half_r <= half_r + 5'h1;
                ST_HOLD:
                    if (!control_r[EN_BIT])
                        state_r <= ST_IDLE;
                    else if (tick && half_r == 5'(HOLD_HALVES - 1))
                        state_r <= ST_IDLE;
                    else if (tick)
                        half_r <= half_r + 5'h1;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // successive approximation, one bit per full conversion period
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            sar_r <= 8'h80;
            bit_r <= 3'h7;
        end
        else if (state_r != ST_CONV)
        begin
            sar_r <= 8'h80;
            bit_r <= 3'h7;
        end
        else if (tick && half_r[0] && half_r < 5'h10)
        begin
            sar_r[bit_r] <= cmp_sync_r[1];
            if (bit_r != 3'h0)
                sar_r[bit_r - 3'h1] <= 1'b1;
            bit_r <= bit_r - 3'h1;
        end
    end

    // result register keeps its value on abort and reset
    always_ff @(posedge SYS_CLK)
    begin
        if (finish && !abort)
            result_r <= sar_r;
    end

    // control register with hardware clear of the start bit
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            control_r <= CONTROL_RST;
        else
        begin
            if (wr_ctl)
            begin
                control_r <= req.writedata;
                // start taken when idle; a running conversion keeps the bit up
                control_r[GO_BIT] <= (go_set && state_r == ST_IDLE)
                                     || (control_r[GO_BIT] && req.writedata[GO_BIT]
                                         && !finish && !abort);
            end
            else if (finish || (control_r[GO_BIT] && abort))
                control_r[GO_BIT] <= 1'b0;
        end
    end

    // port configuration and flags; a set beats a clearing write
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            portcfg_r   <= PORTCFG_RST;
            done_flag_r <= 1'b0;
            pin_flag_r  <= 1'b0;
            edge_flag_r <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                portcfg_r <= req.writedata[2:0];
            if (finish && !abort)
                done_flag_r <= 1'b1;
            else if (req.write && !ack_r && req.address == ADDR_STATUS
                     && req.writedata[ST_DONE_FLAG])
                done_flag_r <= 1'b0;
            if (wr_cfg && req.writedata[2:0] != portcfg_r)
            begin
                pin_flag_r  <= 1'b1;
                edge_flag_r <= 1'b1;
            end
            else if (req.write && !ack_r && req.address == ADDR_STATUS)
            begin
                if (req.writedata[ST_PIN_FLAG])
                    pin_flag_r <= 1'b0;
                if (req.writedata[ST_EDGE_FLAG])
                    edge_flag_r <= 1'b0;
            end
        end
    end

    // avalon slave: one wait cycle, then read data with the release
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            ack_r           <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0;
        end
        else
        begin
            ack_r           <= (req.read || req.write) && !ack_r;
            // waitrequest falls together with ack, straight from a flop
            AVS_WAITREQUEST <= !((req.read || req.write) && !ack_r);
            if (req.read && !ack_r)
            begin
                case (req.address)
                    ADDR_CONTROL: AVS_READDATA <= {24'h0, control_r};
                    ADDR_PORTCFG: AVS_READDATA <= {29'h0, portcfg_r};
                    ADDR_RESULT:  AVS_READDATA <= {24'h0, result_r};
                    ADDR_STATUS:  AVS_READDATA <= {28'h0, state_r == ST_CONV,
                                                   edge_flag_r, pin_flag_r, done_flag_r};
                    default:      AVS_READDATA <= 32'h0;
                endcase
            end
        end
    end

    // analog front-end controls and digital pin values
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            PIN_VALUE      <= 4'h0;
            SAMPLE_CHANNEL <= 2'h0;
            SAMPLE_CONNECT <= 1'b0;
            DAC_CODE       <= 8'h80;
            EXT_REF        <= 1'b0;
            ANALOG_ON      <= 1'b0;
            WAKE           <= 1'b0;
        end
        else
        begin
            PIN_VALUE      <= pin_s2_r & pmap.digital;
            SAMPLE_CHANNEL <= control_r[CHAN_HI:CHAN_LO];
            // capacitor floats while converting or holding, never discharged
            SAMPLE_CONNECT <= ANALOG_ON && (state_r == ST_IDLE || state_r == ST_WAIT);
            DAC_CODE       <= sar_r;
            EXT_REF        <= pmap.ext_ref;
            ANALOG_ON      <= control_r[EN_BIT] && !(slp_sync_r[1]
                              && (control_r[CLKSEL_HI:CLKSEL_LO] != CLK_RC
                                  || state_r == ST_IDLE));
            WAKE           <= slp_sync_r[1] && finish && !abort;
        end
    end

    AST_DONE_TOGETHER: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish && !abort |=> done_flag_r && !control_r[GO_BIT] && result_r == $past(sar_r))
        else $error("completion did not update flag, start bit and result together");
    AST_HOLD_LEN: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish && !abort |=> (state_r == ST_HOLD && !SAMPLE_CONNECT) ##1 !SAMPLE_CONNECT)
        else $error("sample not held off after conversion");
    AST_ABORT_KEEP: assert property (@(posedge SYS_CLK) disable iff (RST)
        state_r == ST_CONV && go_clr |=> $stable(result_r) && state_r == ST_HOLD)
        else $error("abort changed result");
    AST_CFG_RESET: assert property (@(posedge SYS_CLK)
        $rose(!RST) |-> portcfg_r == 3'h0)
        else $error("port config not zero after reset");
    AST_ANALOG_ZERO: assert property (@(posedge SYS_CLK) disable iff (RST)
        1'b1 |=> (PIN_VALUE & ~$past(pmap.digital)) == 4'h0)
        else $error("analog pin read non-zero");
    AST_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
        !control_r[EN_BIT] |=> !ANALOG_ON)
        else $error("converter on while disabled");
    AST_BUSY_GO: assert property (@(posedge SYS_CLK) disable iff (RST)
        state_r == ST_CONV && !finish |-> control_r[GO_BIT] || abort)
        else $error("start bit low during conversion");
    AST_CHAN: assert property (@(posedge SYS_CLK) disable iff (RST)
        1'b1 |=> SAMPLE_CHANNEL == $past(control_r[CHAN_HI:CHAN_LO]))
        else $error("wrong channel routed");
endmodule // acc_top
`default_nettype wire

// ---- verification/acc_analog_model.sv ----
// acc_analog_model: analog inputs, sample capacitor, comparator and rc oscillator
// assumes the bench sets the four channel levels as 8-bit codes
`default_nettype none
module acc_analog_model
(
    input  wire logic        clk,
    input  wire logic [31:0] levels,
    input  wire logic [1:0]  sample_channel,
    input  wire logic        sample_connect,
    input  wire logic [7:0]  dac_code,
    output logic             cmp_in,
    output logic             rc_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cap_r = 8'h00;
    // capacitor tracks the selected channel only while connected, keeps charge otherwise
    // channel pins are only ever inputs here, nothing drives them back
    always @(posedge clk)
    begin
        if (sample_connect)
        begin
            cap_r <= levels[sample_channel * 8 +: 8];
        end
    end
    // comparator: held value at or above the trial code
    assign cmp_in = (cap_r >= dac_code);
    // internal rc oscillator runs free, unrelated in phase to the system clock
    initial
    begin
        rc_tick = 1'b0;
        forever #1937 rc_tick = ~rc_tick;
    end
endmodule // acc_analog_model
`default_nettype wire

// ---- verification/adc_conversion_control_tb.sv ----
// adc_conversion_control_tb: self-checking bench for acc_top
// assumes acc_pkg register map; the analog side is acc_analog_model
`default_nettype none
module adc_conversion_control_tb;
    import acc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYS_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [9:0]  av_addr = 10'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        rc_tick;
    logic        sleep_in = 1'b0;
    logic        cmp_in;
    logic [3:0]  pin_in = 4'h0;
    logic [3:0]  pin_value;
    logic [1:0]  smp_ch;
    logic        smp_conn;
    logic [7:0]  dac;
    logic        ext_ref;
    logic        analog_on;
    logic        wake;
    logic [31:0] levels = 32'h0;
    logic [31:0] q;
    logic [7:0]  lv;
    logic [7:0]  old_res;
    logic [2:0]  prev;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          wakes = 0;
    int          t0;
    int          el;
    int          h;
    int          w0;
    int          seed;

    acc_top dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
        .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
        .AVS_WAITREQUEST(av_wait), .RC_TICK(rc_tick), .SLEEP(sleep_in), .CMP_IN(cmp_in),
        .PIN_IN(pin_in), .PIN_VALUE(pin_value), .SAMPLE_CHANNEL(smp_ch),
        .SAMPLE_CONNECT(smp_conn), .DAC_CODE(dac), .EXT_REF(ext_ref),
        .ANALOG_ON(analog_on), .WAKE(wake));
    acc_analog_model model_u (.clk(SYS_CLK), .levels(levels), .sample_channel(smp_ch),
        .sample_connect(smp_conn), .dac_code(dac), .cmp_in(cmp_in), .rc_tick(rc_tick));

    // 50 ns system clock
    always #25 SYS_CLK = ~SYS_CLK;

    // cycle count, wake pulse count and run ceiling
    always @(posedge SYS_CLK)
    begin
        cycles <= cycles + 1;
        if (wake === 1'b1)
            wakes <= wakes + 1;
        if (cycles == 60000)
        begin
            errors++;
            results();
        end
    end

    task automatic results;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon access; read data land in q
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge SYS_CLK);
        av_addr <= a;
        av_wdata <= {24'h0, d};
        av_wr <= wr;
        av_rd <= ~wr;
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        q = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask

    // pins left digital by each port configuration code, {gp4,gp2,gp1,gp0}
    function automatic logic [3:0] dig_mask(input logic [2:0] c);
        case (c)
            3'h2, 3'h3: return 4'h8;
            3'h4, 3'h5: return 4'hc;
            3'h6: return 4'he;
            3'h7: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction

    // configure, enable, clear flag, acquire, then start
    task automatic start(input logic [1:0] s, input logic [1:0] ch);
        int n = 0;
        bus(1'b1, ADDR_CONTROL, {s, 1'b0, ch, 3'b001});
        bus(1'b1, ADDR_STATUS, 8'h01);
        // acquisition only begins once the hold after the last conversion is over
        while (smp_conn !== 1'b1 && n < 2000)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        chk(32'(smp_conn), 32'h1);
        levels <= $urandom;
        repeat (30) @(posedge SYS_CLK); // acquisition after channel change
        lv = levels[ch * 8 +: 8];
        bus(1'b1, ADDR_CONTROL, {s, 1'b0, ch, 3'b101});
        t0 = cycles;
        chk(32'(smp_ch), 32'(ch));
    endtask

    task automatic wait_done;
        int n = 0;
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(32'(q[GO_BIT]), 32'h1);
        while (q[GO_BIT] !== 1'b0 && n < 400)
        begin
            bus(1'b0, ADDR_CONTROL, 8'h00);
            n++;
        end
        el = cycles - t0;
    endtask

    // main sequence
    initial
    begin
        seed = $urandom(32'h48ca);
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        pin_in <= 4'($urandom);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(q, 32'h0);
        bus(1'b0, ADDR_PORTCFG, 8'h00);
        chk(q, 32'h0);
        chk({ext_ref, pin_value, analog_on}, 6'h0);
        // reserved bits are storage only, unmapped place reads zero
        bus(1'b1, ADDR_CONTROL, 8'h22);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(q, 32'h22);
        chk(32'(analog_on), 32'h0);
        bus(1'b1, 10'h3f0, 8'hff);
        bus(1'b0, 10'h3f0, 8'h00);
        chk(q, 32'h0);
        // start in the same write that enables is not taken
        bus(1'b1, ADDR_CONTROL, 8'h05);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(q, 32'h01);
        chk(32'(analog_on), 32'h1);
        // every port configuration code
        prev = 3'h0;
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, ADDR_STATUS, 8'h06);
            pin_in <= 4'($urandom);
            bus(1'b1, ADDR_PORTCFG, {5'h1f, 3'(c)});
            bus(1'b0, ADDR_PORTCFG, 8'h00);
            chk(q, 32'(c));
            chk(32'(ext_ref), 32'(c == 1 || c == 3 || c == 5));
            chk(32'(pin_value), 32'(pin_in & dig_mask(3'(c))));
            bus(1'b0, ADDR_STATUS, 8'h00);
            chk(q, (3'(c) != prev) ? 32'h6 : 32'h0);
            prev = 3'(c);
        end
        bus(1'b1, ADDR_PORTCFG, 8'h00);
        // conversions with every clock select, random channel and level
        for (int i = 0; i < 8; i++)
        begin
            start(2'(i), 2'($urandom));
            wait_done();
            h = 1 << (2 * (i % 4));
            if (i % 4 != 3)
                chk(32'(el >= 19 * h && el <= 19 * h + 12), 32'h1);
            if (i % 4 == 2)
                chk(32'(smp_conn), 32'h0);
            bus(1'b0, ADDR_RESULT, 8'h00);
            // at sysclk/2 the conversion period is below the legal minimum: result not valid
            if (i % 4 != 0)
                chk(q, 32'(lv));
            else
                chk(q[31:8], 24'h0);
            bus(1'b0, ADDR_STATUS, 8'h00);
            chk(32'(q[ST_DONE_FLAG]), 32'h1);
        end
        // abort by clearing the start bit keeps the old result
        bus(1'b0, ADDR_RESULT, 8'h00);
        old_res = q[7:0];
        start(CLK_DIV32, 2'h1);
        repeat (30) @(posedge SYS_CLK);
        bus(1'b1, ADDR_CONTROL, 8'h89);
        bus(1'b0, ADDR_RESULT, 8'h00);
        chk(q, 32'(old_res));
        chk(32'(smp_conn), 32'h0);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(32'(q[ST_DONE_FLAG]), 32'h0);
        repeat (75) @(posedge SYS_CLK);
        chk(32'(smp_conn), 32'h1);
        // sleep with a divided clock aborts and powers down, enable kept
        bus(1'b0, ADDR_RESULT, 8'h00);
        old_res = q[7:0];
        start(CLK_DIV8, 2'h2);
        repeat (10) @(posedge SYS_CLK);
        sleep_in <= 1'b1;
        repeat (10) @(posedge SYS_CLK);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(q, 32'h51);
        chk(32'(analog_on), 32'h0);
        bus(1'b0, ADDR_RESULT, 8'h00);
        chk(q, 32'(old_res));
        sleep_in <= 1'b0;
        // rc clock conversion completes in sleep and wakes the core
        start(CLK_RC, 2'h3);
        sleep_in <= 1'b1;
        w0 = wakes;
        wait_done();
        chk(32'(el > RC_WAIT_CYC), 32'h1);
        chk(32'(wakes - w0), 32'h1);
        bus(1'b0, ADDR_RESULT, 8'h00);
        chk(q, 32'(lv));
        sleep_in <= 1'b0;
        results();
    end
endmodule // adc_conversion_control_tb
`default_nettype wire
